// ### logic/tlqp_device.sv
// Purpose: trajectory command parser, profile generator and quadrature position counter
// Assumes: host waits for busy low; encoder inputs synchronous enough to sample twice
// Notes:   velocity and acceleration are whole counts per sample period
`timescale 1ns/1ps
`default_nettype none
module tlqp_device
  import tlqp_pkg::*;
#(
  parameter int BUSY_N   = tlqp_pkg::BUSY_CLKS,
  parameter int SAMPLE_N = tlqp_pkg::SAMPLE_CLKS
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // host byte port
  tlqp_if.device                          bus,
  // encoder channels
  input  wire logic                       enc_a,
  input  wire logic                       enc_b,
  // motion state
  output logic [tlqp_pkg::POS_W-1:0]      actual_pos,
  output logic [tlqp_pkg::POS_W-1:0]      desired_pos,
  output logic [tlqp_pkg::POS_W-1:0]      pos_error,
  output logic                            motion_active,
  output logic                            vel_mode
);
  import tlqp_pkg::*;

  localparam int SW = $clog2(SAMPLE_N);

  generate
    if (BUSY_N < 1 || BUSY_N > 255) begin : g_bad_busy
      $error("BUSY_N out of range");
    end
    if (SAMPLE_N < 2 || (1 << SW) != SAMPLE_N) begin : g_bad_sample
      $error("SAMPLE_N must be a power of two");
    end
  endgenerate

  typedef enum logic [4:0] {
    P_IDLE = 5'b00001,
    P_CWHI = 5'b00010,
    P_CWLO = 5'b00100,
    P_WHI  = 5'b01000,
    P_WLO  = 5'b10000
  } tlqp_parse_e;

  typedef struct packed {
    tlqp_parse_e      st;
    logic             busy;
    logic [7:0]       busy_cnt;
    logic [7:0]       byte_hi;
    logic [7:0]       cw_hb;
    logic [7:0]       cw_lb;
    logic [2:0]       words_left;
    logic [2:0]       word_idx;
    logic [POS_W-1:0] buf_acc;
    logic [POS_W-1:0] buf_vel;
    logic [POS_W-1:0] buf_pos;
    logic             pos_new;
    logic             pos_rel;
    logic             buf_vmode;
    logic [2:0]       qa;
    logic [2:0]       qb;
    logic [POS_W-1:0] enc_pos;
    logic [SW-1:0]    samp_cnt;
    logic [POS_W-1:0] samp_pos;
    logic [POS_W-1:0] acc;
    logic [POS_W-1:0] vmax;
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] vel_cur;
    logic [POS_W-1:0] ramp_dist;
    logic             vmode;
    logic             run;
    logic [POS_W-1:0] desired;
    logic [POS_W-1:0] err;
  } tlqp_dev_s;

  tlqp_dev_s s_ff;
  tlqp_dev_s nxt_s;

  // picks which parameter (0 acc, 1 vel, 2 pos) the k-th loaded one is
  function automatic logic [1:0] slot_of(input logic [7:0] lb, input logic [1:0] k);
    logic [1:0] seen;
    logic [1:0] r;
    logic       sel;
    seen = 2'd0;
    r    = 2'd3;
    for (int p = 0; p < 3; p++) begin
      sel = (p == 0) ? lb[LB_ACC] : (p == 1) ? lb[LB_VEL] : lb[LB_POS];
      if (sel) begin
        if (seen == k && r == 2'd3) begin
          r = 2'(p);
        end
        seen = seen + 2'd1;
      end
    end
    return r;
  endfunction

  logic [15:0]      word_in;
  logic [1:0]       slot;
  logic [2:0]       n_words;
  logic             tick;
  logic             q_step;
  logic             q_up;
  logic [POS_W-1:0] rem;
  logic [POS_W-1:0] mag;
  logic [POS_W-1:0] v;
  logic [POS_W-1:0] step;
  logic             dir_fwd;

  always_comb begin
    nxt_s   = s_ff;
    word_in = {s_ff.byte_hi, bus.wbyte};
    slot    = slot_of(s_ff.cw_lb, s_ff.word_idx[2:1]);
    n_words = {1'b0, 2'(bus.wbyte[LB_ACC]) + 2'(bus.wbyte[LB_VEL]) + 2'(bus.wbyte[LB_POS])};
    n_words = {n_words[1:0], 1'b0};
    tick    = (s_ff.samp_cnt == SW'(SAMPLE_N - 1));
    rem     = s_ff.target - s_ff.desired;
    dir_fwd = ~rem[POS_W-1];
    mag     = dir_fwd ? rem : (~rem + 32'h0000_0001);
    v       = s_ff.vel_cur;
    step    = 32'h0000_0000;
    // ----------------------------------------
    // host port parser
    // ----------------------------------------
    if (s_ff.busy) begin
      // writes during busy are dropped, as the host is expected to poll
      nxt_s.busy_cnt = s_ff.busy_cnt - 8'h01;
      if (s_ff.busy_cnt == 8'h01) begin
        nxt_s.busy = 1'b0;
      end
    end else if (bus.wr && bus.sel_cmd) begin
      nxt_s.busy     = 1'b1;
      nxt_s.busy_cnt = 8'(BUSY_N);
      if (bus.wbyte == CMD_LOAD_TRAJ) begin
        nxt_s.st = P_CWHI;
      end else if (bus.wbyte == CMD_START) begin
        nxt_s.st   = P_IDLE;
        nxt_s.acc  = s_ff.buf_acc;
        nxt_s.vmax = s_ff.buf_vel;
        nxt_s.vmode = s_ff.buf_vmode;
        if (!s_ff.run) begin
          nxt_s.desired   = s_ff.enc_pos;
          nxt_s.target    = s_ff.enc_pos;
          nxt_s.vel_cur   = 32'h0000_0000;
          nxt_s.ramp_dist = 32'h0000_0000;
        end
        if (s_ff.pos_new) begin
          nxt_s.target = s_ff.pos_rel ?
                         ((s_ff.run ? s_ff.target : s_ff.enc_pos) + s_ff.buf_pos) :
                         s_ff.buf_pos;
        end
        nxt_s.pos_new = 1'b0;
        nxt_s.run     = 1'b1;
      end else begin
        nxt_s.st = P_IDLE;
      end
    end else if (bus.wr) begin
      case (s_ff.st)
        P_CWHI: begin
          nxt_s.cw_hb = bus.wbyte;
          nxt_s.st    = P_CWLO;
        end
        P_CWLO: begin
          nxt_s.cw_lb      = bus.wbyte;
          nxt_s.buf_vmode  = s_ff.cw_hb[HB_VEL_MODE];
          nxt_s.words_left = n_words;
          nxt_s.word_idx   = 3'd0;
          nxt_s.busy       = 1'b1;
          nxt_s.busy_cnt   = 8'(BUSY_N);
          if (bus.wbyte[LB_POS]) begin
            nxt_s.pos_new = 1'b1;
            nxt_s.pos_rel = bus.wbyte[LB_POS_REL];
          end
          // with no words selected the acc, vel and pos buffers keep their values; buf_vmode still loads
          nxt_s.st = (bus.wbyte == CW_LB_NONE) ? P_IDLE : P_WHI;
        end
        P_WHI: begin
          nxt_s.byte_hi = bus.wbyte;
          nxt_s.st      = P_WLO;
        end
        P_WLO: begin
          nxt_s.busy     = 1'b1;
          nxt_s.busy_cnt = 8'(BUSY_N);
          case (slot)
            2'd0: begin
              if (!s_ff.word_idx[0]) nxt_s.buf_acc[31:16] = word_in;
              else                   nxt_s.buf_acc[15:0]  = word_in;
            end
            2'd1: begin
              if (!s_ff.word_idx[0]) nxt_s.buf_vel[31:16] = word_in;
              else                   nxt_s.buf_vel[15:0]  = word_in;
            end
            2'd2: begin
              if (!s_ff.word_idx[0]) nxt_s.buf_pos[31:16] = word_in;
              else                   nxt_s.buf_pos[15:0]  = word_in;
            end
            default: begin
            end
          endcase
          nxt_s.word_idx   = s_ff.word_idx + 3'd1;
          nxt_s.words_left = s_ff.words_left - 3'd1;
          nxt_s.st = (s_ff.words_left == 3'd1) ? P_IDLE : P_WHI;
        end
        default: begin
          nxt_s.st = P_IDLE;
        end
      endcase
    end
    // ----------------------------------------
    // quadrature decoder
    // ----------------------------------------
    // qa[0]/qb[0] feed only the next stage; qa[2]/qb[2] hold the previous state
    nxt_s.qa = {s_ff.qa[1:0], enc_a};
    nxt_s.qb = {s_ff.qb[1:0], enc_b};
    q_step   = (s_ff.qa[1] ^ s_ff.qa[2]) ^ (s_ff.qb[1] ^ s_ff.qb[2]);
    q_up     = s_ff.qb[2] ^ s_ff.qa[1];
    if (q_step) begin
      nxt_s.enc_pos = q_up ? s_ff.enc_pos + 32'h0000_0001 :
                             s_ff.enc_pos - 32'h0000_0001;
    end
    // ----------------------------------------
    // sampling and profile generator
    // ----------------------------------------
    nxt_s.samp_cnt = s_ff.samp_cnt + SW'(1);
    if (tick) begin
      nxt_s.samp_pos = s_ff.enc_pos;
      nxt_s.err      = s_ff.desired - s_ff.enc_pos;
      // a position move already at its target ends even with zero acceleration
      if (s_ff.run && !s_ff.vmode && mag == 32'h0000_0000) begin
        nxt_s.run     = 1'b0;
        nxt_s.vel_cur = 32'h0000_0000;
      end else if (s_ff.run && s_ff.acc != 32'h0000_0000) begin
        if (s_ff.vmode) begin
          v = (s_ff.vel_cur + s_ff.acc > s_ff.vmax) ? s_ff.vmax : s_ff.vel_cur + s_ff.acc;
          nxt_s.desired = s_ff.desired + v;
          nxt_s.target  = s_ff.desired + v;
          nxt_s.vel_cur = v;
        end else if (mag == 32'h0000_0000) begin
          nxt_s.run     = 1'b0;
          nxt_s.vel_cur = 32'h0000_0000;
        end else begin
          // decelerate once the remaining distance fits the ramp-up distance
          if (mag <= s_ff.ramp_dist) begin
            v = (s_ff.vel_cur > s_ff.acc) ? s_ff.vel_cur - s_ff.acc : s_ff.acc;
          end else if (s_ff.vel_cur < s_ff.vmax) begin
            v = (s_ff.vel_cur + s_ff.acc > s_ff.vmax) ? s_ff.vmax : s_ff.vel_cur + s_ff.acc;
            nxt_s.ramp_dist = s_ff.ramp_dist + v;
          end
          step          = (v > mag) ? mag : v;
          nxt_s.desired = dir_fwd ? s_ff.desired + step : s_ff.desired - step;
          nxt_s.vel_cur = v;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff    <= '0;
      s_ff.st <= P_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.busy      = s_ff.busy;
  assign actual_pos    = s_ff.samp_pos;
  assign desired_pos   = s_ff.desired;
  assign pos_error     = s_ff.err;
  assign motion_active = s_ff.run;
  assign vel_mode      = s_ff.vmode;
endmodule
`default_nettype wire

// ### logic/tlqp_host.sv
// Purpose: host end that sends commands and 16-bit data words over the byte port
// Assumes: one request at a time from the user side
// Notes:   waits for busy to clear after every command and every word
`timescale 1ns/1ps
`default_nettype none
module tlqp_host
  import tlqp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // device byte port
  tlqp_if.host             bus,
  // user requests
  input  wire logic        user_req,
  input  wire logic        user_is_cmd,
  input  wire logic [15:0] user_word,
  output logic             user_ready
);
  import tlqp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LO   = 4'b0010,
    H_END  = 4'b0100,
    H_WAIT = 4'b1000
  } tlqp_host_e;

  typedef struct packed {
    tlqp_host_e st;
    logic       wr;
    logic       sel_cmd;
    logic [7:0] wbyte;
    logic [7:0] lo;
  } tlqp_host_s;

  tlqp_host_s s_ff;
  tlqp_host_s nxt_s;

  // ----------------------------------------
  // byte sequencer
  // ----------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.wr = 1'b0;
    case (s_ff.st)
      H_IDLE: begin
        if (user_req) begin
          nxt_s.wr      = 1'b1;
          nxt_s.sel_cmd = user_is_cmd;
          nxt_s.wbyte   = user_is_cmd ? user_word[7:0] : user_word[15:8];
          nxt_s.lo      = user_word[7:0];
          nxt_s.st      = user_is_cmd ? H_END : H_LO;
        end
      end
      H_LO: begin
        // second byte goes straight out: busy only follows a full word
        nxt_s.wr    = 1'b1;
        nxt_s.wbyte = s_ff.lo;
        nxt_s.st    = H_END;
      end
      H_END: begin
        nxt_s.st = H_WAIT;
      end
      H_WAIT: begin
        if (!bus.busy) begin
          nxt_s.st = H_IDLE;
        end
      end
      default: begin
        nxt_s.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff    <= '0;
      s_ff.st <= H_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.wr      = s_ff.wr;
  assign bus.sel_cmd = s_ff.sel_cmd;
  assign bus.wbyte   = s_ff.wbyte;
  assign user_ready  = (s_ff.st == H_IDLE);
endmodule
`default_nettype wire

// ### logic/tlqp_if.sv
// Purpose: byte port between host and trajectory device
// Assumes: all signals synchronous to clk_sys
// Notes:   sel_cmd high selects the command port, low the data port
`timescale 1ns/1ps
`default_nettype none
interface tlqp_if;
  logic       wr;
  logic       sel_cmd;
  logic [7:0] wbyte;
  logic       busy;
  modport device (input wr, input sel_cmd, input wbyte, output busy);
  modport host   (output wr, output sel_cmd, output wbyte, input busy);
endinterface
`default_nettype wire

// ### logic/tlqp_pkg.sv
// Purpose: shared constants for the trajectory load and quadrature position block
// Assumes: byte-wide host port, single clock
// Notes:   command codes, control word fields and timing counts
package tlqp_pkg;
  // ----------------------------------------
  // command codes and control word fields
  // ----------------------------------------
  localparam logic [7:0] CMD_LOAD_TRAJ = 8'h1F;
  localparam logic [7:0] CMD_START     = 8'h01;
  localparam logic [7:0] CW_LB_NONE    = 8'h00;
  localparam int         LB_POS_REL    = 0;
  localparam int         LB_POS        = 1;
  localparam int         LB_VEL        = 3;
  localparam int         LB_ACC        = 5;
  localparam int         HB_VEL_MODE   = 3;
  // ----------------------------------------
  // widths and timing counts
  // ----------------------------------------
  localparam int         POS_W         = 32;
  localparam int         SAMPLE_CLKS   = 2048;
  localparam int         BUSY_CLKS     = 4;
  localparam logic [31:0] POS_RESET    = 32'h0000_0000;
endpackage

// ### sim/tlqp_monitor.sv
// Purpose: concurrent checks on the byte port between host and device
// Assumes: BUSY_N left at its default of 4
// Notes:   byte parity is tracked here, cleared by any command byte
`timescale 1ns/1ps
`default_nettype none
module tlqp_monitor
  import tlqp_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // byte port
  input wire logic       wr,
  input wire logic       sel_cmd,
  input wire logic [7:0] wbyte,
  input wire logic       busy
);
  import tlqp_pkg::*;
  logic byte_odd_ff;
  logic nxt_byte_odd;
  // ----------------------------------------
  // byte parity of the data port
  // ----------------------------------------
  always_comb begin
    nxt_byte_odd = byte_odd_ff;
    if (wr && !busy) begin
      nxt_byte_odd = sel_cmd ? 1'b0 : ~byte_odd_ff;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byte_odd_ff <= 1'b0;
    end else begin
      byte_odd_ff <= nxt_byte_odd;
    end
  end
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  cmd_busy_a: assert property (wr && sel_cmd && !busy |=> busy)
    else $error("no busy after command byte");
  busy_len_a: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
    else $error("busy length wrong");
  busy_cause_a: assert property ($rose(busy) |-> $past(wr))
    else $error("busy without a write");
  host_wait_a: assert property (busy |-> !wr)
    else $error("write while busy");
  hi_quiet_a: assert property (wr && !sel_cmd && !busy && !byte_odd_ff |=> !busy)
    else $error("busy after first byte of word");
  lo_busy_a: assert property (wr && !sel_cmd && !busy && byte_odd_ff |=> busy)
    else $error("no busy after second byte");
  word_pair_a: assert property (wr && !sel_cmd && !byte_odd_ff |=> wr && !sel_cmd)
    else $error("word not sent whole");
  cmd_code_a: assert property (wr && sel_cmd |-> wbyte == CMD_LOAD_TRAJ || wbyte == CMD_START)
    else $error("unexpected command code");
  cmd_pulse_a: assert property (wr && sel_cmd |=> !wr)
    else $error("command strobe too long");
endmodule
`default_nettype wire

// ### sim/tlqp_testbench.sv
// Purpose: self-checking bench, host end driving device end
// Assumes: sample period shortened to 16 clocks
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t 0x%0h 0x%0h", $time, a, e); end end
module testbench;
  import tlqp_pkg::*;
  localparam int SN = 16;
  logic        clk_sys;
  logic        rst_n;
  logic        enc_a;
  logic        enc_b;
  logic        user_req;
  logic        user_is_cmd;
  logic [15:0] user_word;
  logic        user_ready;
  logic [31:0] actual_pos;
  logic [31:0] desired_pos;
  logic [31:0] pos_error;
  logic        motion_active;
  logic        vel_mode;
  logic [31:0] exp_d;
  int          error_cnt;
  int          checks;
  int          q;
  tlqp_if bus_if ();
  tlqp_host tlqp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if),
    .user_req(user_req), .user_is_cmd(user_is_cmd), .user_word(user_word),
    .user_ready(user_ready));
  tlqp_device #(.SAMPLE_N(SN)) tlqp_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus_if), .enc_a(enc_a), .enc_b(enc_b), .actual_pos(actual_pos),
    .desired_pos(desired_pos), .pos_error(pos_error), .motion_active(motion_active),
    .vel_mode(vel_mode));
  tlqp_monitor tlqp_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wr(bus_if.wr),
    .sel_cmd(bus_if.sel_cmd), .wbyte(bus_if.wbyte), .busy(bus_if.busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? bus_if.busy : (s == 1) ? user_ready : motion_active;
  endfunction
  // bounded wait; a hang ends the run
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (sig(s) !== v) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 20000) begin
        error_cnt++;
        $display("BAD %0t 0x%0h 0x%0h", $time, s, v);
        test_done();
      end
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * SN) @(posedge clk_sys);
    #1;
  endtask
  task automatic send(input logic c, input logic [15:0] w);
    wt(1, 1'b1);
    user_req = 1'b1;
    user_is_cmd = c;
    user_word = w;
    @(posedge clk_sys);
    #1;
    user_req = 1'b0;
    wt(0, 1'b1);
    wt(1, 1'b1);
  endtask
  task automatic word32(input logic [31:0] v);
    send(1'b0, v[31:16]);
    send(1'b0, v[15:0]);
  endtask
  // gray walk; dir +1 lets channel a lead
  task automatic enc(input int n, input int dir);
    repeat (n) begin
      q = (q + dir) & 3;
      enc_a = q[1] ^ q[0];
      enc_b = q[1];
      repeat (4) @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic move(input logic [7:0] lb, input logic [31:0] a, v, p, e);
    send(1'b1, {8'h00, CMD_LOAD_TRAJ});
    send(1'b0, {8'h00, lb});
    if (lb[LB_ACC]) word32(a);
    if (lb[LB_VEL]) word32(v);
    if (lb[LB_POS]) word32(p);
    ticks(3);
    `CHK(desired_pos, exp_d)
    send(1'b1, {8'h00, CMD_START});
    wt(2, 1'b0);
    `CHK(desired_pos, e)
    `CHK(vel_mode, 1'b0)
    exp_d = e;
    ticks(3);
    `CHK(desired_pos, e)
    `CHK(motion_active, 1'b0)
    $display("test move 0x%0h done", lb);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    user_req = 1'b0;
    user_is_cmd = 1'b0;
    user_word = 16'h0000;
    enc_a = 1'b0;
    enc_b = 1'b0;
    error_cnt = 0;
    checks = 0;
    q = 0;
    exp_d = 32'h0000_0000;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    `CHK(desired_pos, POS_RESET)
    enc(8, 1);
    enc(3, -1);
    ticks(2);
    `CHK(actual_pos, 32'h0000_0005)
    $display("test encoder done");
    move(8'h00, 32'h0, 32'h0, 32'h0, 32'h0000_0005);
    enc(2, 1);
    ticks(2);
    `CHK(actual_pos, 32'h0000_0007)
    `CHK(desired_pos, 32'h0000_0005)
    `CHK(pos_error, 32'hFFFF_FFFE)
    // acc, vel, pos then keep acc, then relative backwards past zero
    move(8'h2A, 32'h0000_0001, 32'h0000_0004, 32'h0000_0020, 32'h0000_0020);
    move(8'h0A, 32'h0, 32'h0000_0002, 32'h0000_0008, 32'h0000_0008);
    move(8'h2B, 32'h0000_0002, 32'h0000_0003, 32'hFFFF_FFF0, 32'hFFFF_FFF7);
    // velocity mode: upper byte bit 3, acc and vel loaded, runs on
    send(1'b1, {8'h00, CMD_LOAD_TRAJ});
    send(1'b0, 16'h0828);
    word32(32'h0000_0001);
    word32(32'h0000_0002);
    send(1'b1, {8'h00, CMD_START});
    ticks(2);
    `CHK(vel_mode, 1'b1)
    `CHK(motion_active, 1'b1)
    `CHK(desired_pos > 32'h0000_0007, 1'b1)
    $display("test velocity mode done");
    test_done();
  end
endmodule
`default_nettype wire
